// ==== common/adcs_pkg.sv ====
/*
  Constants, types and decode functions for the serial converter control block.
  Assumes a 125 MHz system clock; all link pins are sampled into that domain.
*/
`default_nettype none

package adcs_pkg;

  // ==========================================================================
  // Control byte layout
  localparam int          CTRL_LEN      = 8;
  localparam int          CTRL_START    = 7;
  localparam int          CTRL_CHAN_HI  = 6;
  localparam int          CTRL_CHAN_LO  = 4;
  localparam int          CTRL_POL      = 3;
  localparam int          CTRL_SGL      = 2;
  localparam int          CTRL_PD_HI    = 1;
  localparam int          CTRL_PD_LO    = 0;
  localparam logic [3:0]  CTRL_CNT_ZERO = 4'h0;
  localparam logic [3:0]  CTRL_CNT_ONE  = 4'h1;
  localparam logic [3:0]  CTRL_CNT_ACQ  = 4'h5;
  localparam logic [3:0]  CTRL_CNT_FULL = 4'h8;
  localparam logic [7:0]  CTRL_FIRST    = 8'h01;

  // ==========================================================================
  // Power and clock mode codes
  localparam logic [1:0]  PD_EXT_CLK    = 2'h3;
  localparam logic [1:0]  PD_INT_CLK    = 2'h2;
  localparam logic [1:0]  PD_FAST_DOWN  = 2'h1;
  localparam logic [1:0]  PD_FULL_DOWN  = 2'h0;

  // ==========================================================================
  // Result framing
  localparam int          RES_LEN       = 12;
  localparam logic [3:0]  OUT_CNT_ZERO  = 4'h0;
  localparam logic [3:0]  OUT_CNT_B3    = 4'h7;
  localparam logic [3:0]  OUT_CNT_LAST  = 4'hC;
  localparam logic [11:0] RES_ZERO      = 12'h000;
  localparam logic [11:0] RES_SIGN_FLIP = 12'h800;

  // ==========================================================================
  // Timing
  localparam int          MCLK_PERIOD_NS  = 8;
  localparam int          CONV_TIME_NS    = 10000;
  localparam int          CONV_CYCLES_INT = CONV_TIME_NS / MCLK_PERIOD_NS;
  localparam int          CONV_CNT_W      = 11;
  localparam logic [10:0] CONV_CYCLES     = CONV_CNT_W'(CONV_CYCLES_INT);
  localparam logic [10:0] CONV_CNT_ZERO   = 11'h000;
  localparam logic [10:0] CONV_CNT_ONE    = 11'h001;

  // ==========================================================================
  // Pin sampling order and reset levels
  localparam int          PIN_W    = 4;
  localparam int          PIN_SCLK = 0;
  localparam int          PIN_DIN  = 1;
  localparam int          PIN_CS   = 2;
  localparam int          PIN_HARD_POWERDOWN_PIN = 3;
  localparam logic [3:0]  PIN_RST  = 4'hC;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_CFG    = {6'h00, PD_INT_CLK};
  localparam logic        RST_STROBE = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXT  = 4'h2,
    ST_INT  = 4'h4,
    ST_READ = 4'h8
  } adcs_state_t;

  // True when the clock mode runs the conversion from the serial clock
  function automatic logic adcs_is_ext(input logic [1:0] mode);
    return mode == PD_EXT_CLK;
  endfunction : adcs_is_ext

  // Power-down codes keep the last clock mode for the one pending conversion
  function automatic logic [1:0] adcs_clk_mode(input logic [1:0] pd, input logic [1:0] last);
    return pd[1] ? pd : last;
  endfunction : adcs_clk_mode

endpackage : adcs_pkg

`default_nettype wire

// ==== hw/adcs_pin_sync.sv ====
/*
  Two-flop synchroniser with edge detection for the serial link pins.
  Assumes pins are asynchronous to mclk and slower than a quarter of its rate.
*/
`timescale 1ns/1ps
`default_nettype none

module adcs_pin_sync
  import adcs_pkg::*;
#(
  parameter logic [PIN_W-1:0] RST_VAL = PIN_RST
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Raw pins
  input  wire logic [PIN_W-1:0] pinIn,
  // Sampled levels and edges
  output logic      [PIN_W-1:0] pinLvl,
  output logic      [PIN_W-1:0] pinRise,
  output logic      [PIN_W-1:0] pinFall
);

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] stable;
    logic [PIN_W-1:0] last;
  } adcs_sync_t;

  adcs_sync_t sync_q;
  adcs_sync_t sync_d;

  // ==========================================================================
  // Sampling chain
  always_comb begin
    sync_d        = sync_q;
    sync_d.meta   = pinIn;
    sync_d.stable = sync_q.meta;
    sync_d.last   = sync_q.stable;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_q <= '{meta: RST_VAL, stable: RST_VAL, last: RST_VAL};
    end else begin
      sync_q <= sync_d;
    end
  end

  // ==========================================================================
  // Edges from the stable stage only
  assign pinLvl  = sync_q.stable;
  assign pinRise = sync_q.stable & ~sync_q.last;
  assign pinFall = ~sync_q.stable & sync_q.last;

endmodule : adcs_pin_sync

`default_nettype wire

// ==== hw/adcs_serial_ctrl.sv ====
/*
  Serial control byte framing and conversion sequencing for a multi-channel
  successive-approximation converter, seen from inside the device.
  Assumes the serial clock, chip select, data input and shutdown pin arrive
  asynchronously and far slower than mclk; the analog core presents a 12-bit
  offset-binary code that is valid whenever sampleTake pulses.
*/
// Operation
// - With chip select low, each rising serial clock captures one input bit.
// - Leading zeros are ignored; the first one bit opens the control byte.
// - Byte: start, channel 3 bits, polarity, input config, power/clock 2 bits.
// - Mode field: 11 external, 10 internal, 01 fast down, 00 full down.
// - Conversion begins on the falling edge after the eighth bit.
// - Track/hold acquires while the last three control bits shift in.
// - External mode: strobe high one serial period after the control byte.
// - External mode: twelve decisions on twelve falls, ten data then two sub.
// - Data output and the external-mode strobe change on falling edges, result MSB first.
// - Unipolar codes straight binary, bipolar codes two's complement.
// - External mode: chip select high floats outputs; next select drives low.
// - Internal mode: strobe low at start, high at end, low at most 10 us.
// - Internal mode: result held; first fall after strobe rise gives MSB.
// - Chip select high blocks input, floats output, internal conversion runs on.
// - Internal mode keeps driving the strobe while chip select is high.
// - Start accepted when idle, or once result bit three is on the output.
// - Chip select fall forcing an early start aborts and restarts conversion.
// - Reset enters internal clock mode with strobe high, ready for a start.
// - Until the first conversion the data output shifts zeros.
// - Three-byte transfer returns zero, ten data, two sub, three zeros.
// - Shutdown pin low forces full power-down and aborts conversion at once.
`timescale 1ns/1ps
`default_nettype none

module adcs_serial_ctrl
  import adcs_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  output logic             dout,
  output logic             doutOe,
  output logic             conversionStrobe,
  output logic             conversionStrobeOe,
  // Hardware power-down pin
  input  wire logic        hardPowerdownN,
  // Converter core
  input  wire logic [11:0] analogCode,
  output logic             trackHold,
  output logic             sampleTake,
  output logic             converting,
  // Configuration status
  output logic [2:0]       channelSel,
  output logic             polaritySelect,
  output logic             inputConfigSelect,
  output logic [1:0]       powerClockSel,
  output logic             externalClockMode,
  // Power status
  output logic             poweredDown,
  output logic             fastPowerdown
);

  // ==========================================================================
  // Pin sampling
  logic [PIN_W-1:0] pinLvl;
  logic [PIN_W-1:0] pinRise;
  logic [PIN_W-1:0] pinFall;

  adcs_pin_sync #(
    .RST_VAL (PIN_RST)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pinIn   ({hardPowerdownN, csN, din, sclk}),
    .pinLvl  (pinLvl),
    .pinRise (pinRise),
    .pinFall (pinFall)
  );

  logic sclkRise;
  logic sclkFall;
  logic dinLvl;
  logic csLow;
  logic csFall;
  logic shdnLow;

  assign sclkRise = pinRise[PIN_SCLK];
  assign sclkFall = pinFall[PIN_SCLK];
  assign dinLvl   = pinLvl[PIN_DIN];
  assign csLow    = ~pinLvl[PIN_CS];
  assign csFall   = pinFall[PIN_CS];
  assign shdnLow  = ~pinLvl[PIN_HARD_POWERDOWN_PIN];

  // ==========================================================================
  // State
  typedef struct packed {
    adcs_state_t       st;
    logic [3:0]        ctrlCnt;
    logic [7:0]        ctrl;
    logic              csArm;
    logic [1:0]        clkMode;
    logic [7:0]        cfg;
    logic [11:0]       result;
    logic [3:0]        outCnt;
    logic [10:0]       convCnt;
    logic              doutBit;
    logic              strobe;
    logic              acquire;
    logic              sample;
    logic              pwrDown;
    logic              pendDown;
  } adcs_ctrl_t;

  adcs_ctrl_t ctl_q;
  adcs_ctrl_t ctl_d;

  logic       startOk;
  logic       pastB3;
  logic [1:0] newMode;
  logic       earlyAbort;

  // ==========================================================================
  // Next state
  always_comb begin
    ctl_d        = ctl_q;
    ctl_d.sample = 1'b0;
    newMode      = adcs_clk_mode(ctl_q.ctrl[CTRL_PD_HI:CTRL_PD_LO], ctl_q.clkMode);
    pastB3       = (ctl_q.st == ST_EXT || ctl_q.st == ST_READ)
                   && ctl_q.outCnt >= OUT_CNT_B3;
    startOk      = ctl_q.st == ST_IDLE || pastB3 || ctl_q.csArm;
    earlyAbort   = ctl_q.csArm && ctl_q.st != ST_IDLE && !pastB3;

    // Chip select fall arms a forced start and, in external clock mode, restores a driven low strobe
    if (csFall) begin
      ctl_d.csArm = 1'b1;
      if (adcs_is_ext(ctl_q.clkMode)) begin
        ctl_d.strobe = 1'b0;
      end
    end

    // Internal conversion timer
    if (ctl_q.st == ST_INT) begin
      if (ctl_q.convCnt == CONV_CYCLES - CONV_CNT_ONE) begin
        ctl_d.st     = ST_READ;
        ctl_d.strobe = 1'b1;
      end else begin
        ctl_d.convCnt = ctl_q.convCnt + CONV_CNT_ONE;
      end
    end

    // Control byte capture on rising edges while selected
    if (sclkRise && csLow) begin
      if (ctl_q.ctrlCnt == CTRL_CNT_ZERO) begin
        if (dinLvl && startOk) begin
          ctl_d.ctrl    = CTRL_FIRST;
          ctl_d.ctrlCnt = CTRL_CNT_ONE;
          ctl_d.csArm   = 1'b0;
          ctl_d.pwrDown = 1'b0;
          if (earlyAbort) begin
            ctl_d.st      = ST_IDLE;
            ctl_d.result  = RES_ZERO;
            ctl_d.doutBit = 1'b0;
          end
        end
      end else if (ctl_q.ctrlCnt != CTRL_CNT_FULL) begin
        ctl_d.ctrl    = {ctl_q.ctrl[CTRL_LEN-2:0], dinLvl};
        ctl_d.ctrlCnt = ctl_q.ctrlCnt + CTRL_CNT_ONE;
      end
    end

    // Falling edges: conversion start and result shifting
    if (sclkFall) begin
      if (ctl_q.ctrlCnt == CTRL_CNT_FULL) begin
        ctl_d.ctrlCnt  = CTRL_CNT_ZERO;
        ctl_d.cfg      = ctl_q.ctrl;
        ctl_d.clkMode  = newMode;
        ctl_d.pendDown = ~ctl_q.ctrl[CTRL_PD_HI];
        ctl_d.sample   = 1'b1;
        ctl_d.outCnt   = OUT_CNT_ZERO;
        ctl_d.doutBit  = 1'b0;
        ctl_d.convCnt  = CONV_CNT_ZERO;
        if (ctl_q.ctrl[CTRL_POL]) begin
          ctl_d.result = analogCode;
        end else begin
          ctl_d.result = analogCode ^ RES_SIGN_FLIP;
        end
        if (adcs_is_ext(newMode)) begin
          ctl_d.st     = ST_EXT;
          ctl_d.strobe = 1'b1;
        end else begin
          ctl_d.st     = ST_INT;
          ctl_d.strobe = 1'b0;
        end
      end else begin
        unique case (ctl_q.st)
          ST_EXT, ST_READ: begin
            ctl_d.strobe = ctl_q.st == ST_READ;
            if (ctl_q.outCnt != OUT_CNT_LAST) begin
              ctl_d.doutBit = ctl_q.result[RES_LEN-1];
              ctl_d.result  = {ctl_q.result[RES_LEN-2:0], 1'b0};
              ctl_d.outCnt  = ctl_q.outCnt + CTRL_CNT_ONE;
            end else begin
              ctl_d.doutBit = 1'b0;
              ctl_d.st      = ST_IDLE;
              ctl_d.pwrDown = ctl_q.pendDown;
            end
          end
          ST_INT: begin
            ctl_d.doutBit = 1'b0;
          end
          ST_IDLE: begin
            ctl_d.doutBit = 1'b0;
          end
          default: begin
            ctl_d.st = ST_IDLE;
          end
        endcase
      end
    end

    // Acquisition window over the last three control bits
    ctl_d.acquire = ctl_d.ctrlCnt >= CTRL_CNT_ACQ;

    // Hardware shutdown overrides sequencing, data output and power fields; strobe, result and clock mode keep their values
    if (shdnLow) begin
      ctl_d.st       = ST_IDLE;
      ctl_d.ctrlCnt  = CTRL_CNT_ZERO;
      ctl_d.csArm    = 1'b0;
      ctl_d.acquire  = 1'b0;
      ctl_d.sample   = 1'b0;
      ctl_d.doutBit  = 1'b0;
      ctl_d.pwrDown  = 1'b1;
      ctl_d.pendDown = 1'b0;
      ctl_d.cfg[CTRL_PD_HI:CTRL_PD_LO] = PD_FULL_DOWN;
    end
  end

  // ==========================================================================
  // Register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_q.st       <= ST_IDLE;
      ctl_q.ctrlCnt  <= CTRL_CNT_ZERO;
      ctl_q.ctrl     <= '0;
      ctl_q.csArm    <= 1'b0;
      ctl_q.clkMode  <= PD_INT_CLK;
      ctl_q.cfg      <= RST_CFG;
      ctl_q.result   <= RES_ZERO;
      ctl_q.outCnt   <= OUT_CNT_ZERO;
      ctl_q.convCnt  <= CONV_CNT_ZERO;
      ctl_q.doutBit  <= 1'b0;
      ctl_q.strobe   <= RST_STROBE;
      ctl_q.acquire  <= 1'b0;
      ctl_q.sample   <= 1'b0;
      ctl_q.pwrDown  <= 1'b0;
      ctl_q.pendDown <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ==========================================================================
  // Pin drivers
  assign dout               = ctl_q.doutBit;
  assign doutOe             = csLow;
  assign conversionStrobe   = ctl_q.strobe;
  assign conversionStrobeOe = csLow || !adcs_is_ext(ctl_q.clkMode);

  // ==========================================================================
  // Core and status outputs
  assign trackHold         = ctl_q.acquire;
  assign sampleTake        = ctl_q.sample;
  assign converting        = ctl_q.st == ST_EXT || ctl_q.st == ST_INT;
  assign channelSel        = ctl_q.cfg[CTRL_CHAN_HI:CTRL_CHAN_LO];
  assign polaritySelect    = ctl_q.cfg[CTRL_POL];
  assign inputConfigSelect = ctl_q.cfg[CTRL_SGL];
  assign powerClockSel     = ctl_q.cfg[CTRL_PD_HI:CTRL_PD_LO];
  assign externalClockMode = adcs_is_ext(ctl_q.clkMode);
  assign poweredDown       = ctl_q.pwrDown;
  assign fastPowerdown     = ctl_q.pwrDown && !shdnLow
                             && ctl_q.cfg[CTRL_PD_HI:CTRL_PD_LO] == PD_FAST_DOWN;

endmodule : adcs_serial_ctrl

`default_nettype wire

// ==== sim/adcs_host_model.sv ====
/*
  Host serial master model: idle-low clock, data sampled on rising edges.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module adcs_host_model (
  // Link pins
  output logic     sclk,
  output logic     csN,
  output logic     din,
  input wire logic dout
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b0;
  end

  // ==========================================================================
  // Frame control
  task automatic select;
    csN = 1'b0;
    #(2 * HALF);
  endtask : select

  task automatic deselect;
    #(HALF);
    csN = 1'b1;
    din = ~din;
  endtask : deselect

  // One byte MSB first, data set after the fall and taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #(HALF);
      sclk = 1'b1;
      rx[i] = dout;
      #(HALF);
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : adcs_host_model

`default_nettype wire

// ==== sim/adcs_ctrl_checker.sv ====
/*
  Assertions on the ports of adcs_serial_ctrl.
  Assumes link pins far slower than mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module adcs_ctrl_checker
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Link
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic       dout,
  input wire logic       doutOe,
  input wire logic       conversionStrobe,
  input wire logic       conversionStrobeOe,
  input wire logic       hardPowerdownN,
  // Core and status
  input wire logic       trackHold,
  input wire logic       sampleTake,
  input wire logic       converting,
  input wire logic [1:0] powerClockSel,
  input wire logic       externalClockMode,
  input wire logic       poweredDown
);
  localparam int LOW_MAX = 1260;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Helper counters
  logic        sclkPrev_q;
  logic [7:0]  sinceFall_q;
  logic [10:0] lowCnt_q;
  always_ff @(posedge mclk) begin
    sclkPrev_q <= sclk;
    if (sys_rst || (sclkPrev_q && !sclk)) sinceFall_q <= 8'h00;
    else if (sinceFall_q != 8'hFF) sinceFall_q <= sinceFall_q + 8'h01;
    if (converting && !externalClockMode && !conversionStrobe) lowCnt_q <= lowCnt_q + 11'h001;
    else lowCnt_q <= 11'h000;
  end

  // ==========================================================================
  // Sequences
  sequence s_strobe_period;
    conversionStrobe [*8] ##1 conversionStrobe [*6] ##[1:4] !conversionStrobe;
  endsequence
  sequence s_hold_window;
    trackHold [*8] ##1 trackHold [*8];
  endsequence

  // ==========================================================================
  // Assertions
  a_reset_state: assert property ($fell(sys_rst) |-> conversionStrobe && !dout)
    else $error("strobe or data wrong after reset");
  a_dout_on_fall: assert property ($changed(dout) && hardPowerdownN |-> sinceFall_q <= 8'h06)
    else $error("data output moved away from a clock fall");
  a_dout_float: assert property (csN [*4] |-> !doutOe)
    else $error("data output driven while deselected");
  a_ext_strobe_float: assert property (csN [*4] ##0 externalClockMode |-> !conversionStrobeOe)
    else $error("strobe driven while deselected in external mode");
  a_int_strobe_drive: assert property (!externalClockMode |-> conversionStrobeOe)
    else $error("strobe released in internal mode");
  a_ext_strobe_pulse: assert property ($rose(conversionStrobe) && externalClockMode |-> s_strobe_period)
    else $error("strobe pulse not one serial period");
  a_int_low_bound: assert property (lowCnt_q <= 11'(LOW_MAX))
    else $error("strobe low too long in internal mode");
  a_take_converts: assert property (sampleTake |-> ##1 !sampleTake ##0 converting [*8])
    else $error("sample pulse without conversion");
  a_track_window: assert property ($rose(trackHold) |-> s_hold_window)
    else $error("track window too short");
  a_shutdown_abort: assert property (!hardPowerdownN [*5] |-> !converting && poweredDown
                                     && powerClockSel == PD_FULL_DOWN)
    else $error("shutdown pin did not abort");
endmodule : adcs_ctrl_checker

bind adcs_serial_ctrl adcs_ctrl_checker adcs_ctrl_checker_i (.mclk(mclk), .sys_rst(sys_rst),
  .sclk(sclk), .csN(csN), .dout(dout), .doutOe(doutOe), .conversionStrobe(conversionStrobe),
  .conversionStrobeOe(conversionStrobeOe), .hardPowerdownN(hardPowerdownN),
  .trackHold(trackHold), .sampleTake(sampleTake), .converting(converting),
  .powerClockSel(powerClockSel), .externalClockMode(externalClockMode),
  .poweredDown(poweredDown));

`default_nettype wire

// ==== sim/test_serial_adc_conversion_control.sv ====
/*
  Self-checking bench for adcs_serial_ctrl with a host model on the link.
  Assumes the package constants and a 125 MHz mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module test_serial_adc_conversion_control
  import adcs_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        mclk, sys_rst, sclk, csN, din, hardPowerdownN;
  logic        dout, doutOe, conversionStrobe, conversionStrobeOe, converting;
  logic        polaritySelect, inputConfigSelect, externalClockMode, poweredDown;
  logic        fastPowerdown;
  logic [11:0] analogCode;
  logic [2:0]  channelSel;
  logic [1:0]  powerClockSel;
  logic [7:0]  rb1, rb2, rb3;
  int          mismatches = 0;
  int          compares = 0;

  adcs_serial_ctrl adcs_serial_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
    .csN(csN), .din(din), .dout(dout), .doutOe(doutOe), .conversionStrobe(conversionStrobe),
    .conversionStrobeOe(conversionStrobeOe), .hardPowerdownN(hardPowerdownN),
    .analogCode(analogCode), .trackHold(), .sampleTake(), .converting(converting),
    .channelSel(channelSel), .polaritySelect(polaritySelect),
    .inputConfigSelect(inputConfigSelect), .powerClockSel(powerClockSel),
    .externalClockMode(externalClockMode), .poweredDown(poweredDown),
    .fastPowerdown(fastPowerdown));
  adcs_host_model adcs_host_model_i (.sclk(sclk), .csN(csN), .din(din),
    .dout(doutOe ? dout : ~dout));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] expect_res(input logic [11:0] c, input logic uni);
    logic [11:0] v;
    v = uni ? c : c ^ RES_SIGN_FLIP;
    return {1'b0, v, 3'b000};
  endfunction : expect_res

  task automatic frame(input logic [7:0] ctl, input logic [7:0] b2);
    adcs_host_model_i.select();
    adcs_host_model_i.xfer(8'h00, rb1);
    adcs_host_model_i.xfer(8'h00, rb1);
    adcs_host_model_i.xfer(ctl, rb1);
    adcs_host_model_i.xfer(b2, rb2);
    adcs_host_model_i.xfer(8'h00, rb3);
    adcs_host_model_i.deselect();
  endtask : frame

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    repeat (2) @(negedge mclk);
    check({9'h000, conversionStrobe, conversionStrobeOe, dout, doutOe, externalClockMode,
           powerClockSel}, 16'h0062);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ext(input logic [11:0] code, input logic [7:0] ctl, input logic [7:0] b2);
    @(negedge mclk);
    analogCode = code;
    frame(ctl, b2);
    check({8'h00, rb1}, 16'h0000);
    check({rb2, rb3}, expect_res(code, ctl[3]));
    check({9'h000, channelSel, polaritySelect, inputConfigSelect, powerClockSel},
          {9'h000, ctl[6:0]});
    check({15'h0000, externalClockMode}, 16'h0001);
    check({14'h0000, poweredDown, fastPowerdown}, {14'h0000, ~ctl[1], ~ctl[1] & ctl[0]});
    $display("test ext done");
  endtask : t_ext

  task automatic t_shutdown;
    adcs_host_model_i.select();
    adcs_host_model_i.xfer(8'hF3, rb1);
    adcs_host_model_i.xfer(8'h00, rb2);
    @(negedge mclk);
    check({15'h0000, converting}, 16'h0001);
    hardPowerdownN = 1'b0;
    repeat (8) @(negedge mclk);
    check({12'h000, converting, poweredDown, powerClockSel}, 16'h0004);
    hardPowerdownN = 1'b1;
    adcs_host_model_i.deselect();
    $display("test shutdown done");
  endtask : t_shutdown

  task automatic t_internal;
    int n;
    n = 0;
    @(negedge mclk);
    analogCode = 12'h6B1;
    adcs_host_model_i.select();
    adcs_host_model_i.xfer(8'hDE, rb1);
    adcs_host_model_i.deselect();
    repeat (8) @(negedge mclk);
    analogCode = 12'h000;
    check({13'h0000, conversionStrobe, conversionStrobeOe, doutOe}, 16'h0002);
    check({14'h0000, powerClockSel}, {14'h0000, PD_INT_CLK});
    while (conversionStrobe !== 1'b1 && n < 1400) begin
      @(negedge mclk);
      n++;
    end
    check({14'h0000, conversionStrobe, converting}, 16'h0002);
    adcs_host_model_i.select();
    adcs_host_model_i.xfer(8'h00, rb2);
    adcs_host_model_i.xfer(8'h00, rb3);
    adcs_host_model_i.deselect();
    check({rb2, rb3}, expect_res(12'h6B1, 1'b1));
    $display("test internal done");
  endtask : t_internal

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    hardPowerdownN = 1'b1;
    analogCode = 12'h000;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    repeat (12500) @(negedge mclk);
    t_ext(12'hA5C, 8'hFF, 8'h80);
    t_ext(12'h3C7, 8'h81, 8'h00);
    t_shutdown();
    t_internal();
    final_report();
  end

  initial begin
    #400000;
    mismatches++;
    final_report();
  end
endmodule : test_serial_adc_conversion_control

`default_nettype wire
